// ---- bench/t2crb_partner.sv ----
// Far-side model: trigger pin driver and other-timer overflow source
`timescale 1ns/10ps
module t2crb_partner (
  input wire logic clk,
  input wire logic rst,
  input wire logic fall_req,
  input wire logic hold_low,
  input wire logic ovf_en,
  output logic pin,
  output logic tmr1_ovf,
  output int ovf_total
);
  // ==========================================================
  // Pulse state
  int low_cnt;
  int gap;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      low_cnt <= 0;
      gap <= 0;
      tmr1_ovf <= 1'b0;
      ovf_total <= 0;
    end else begin
      if (fall_req) low_cnt <= 4;
      else if (low_cnt > 0) low_cnt <= low_cnt - 1;
      gap <= (gap == 6) ? 0 : gap + 1;
      tmr1_ovf <= ovf_en && (gap == 6);
      if (ovf_en && gap == 6) ovf_total <= ovf_total + 1;
    end
  end
  // ==========================================================
  // Pin idles high; low pulse outlasts the two-flop synchroniser
  assign pin = !(hold_low || low_cnt > 0);
endmodule : t2crb_partner

// ---- bench/tb_top.sv ----
// Self-checking bench of the timer block with a register model
`timescale 1ns/10ps
`include "t2crb_defs.svh"
module tb_top;
  // ==========================================================
  // Signals
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, pin, tmr1_ovf, rx_tick, tx_tick, irq;
  logic fall_req = 1'b0;
  logic hold_low = 1'b0;
  logic ovf_en = 1'b0;
  logic ser13 = 1'b0;
  int ovf_total, err_count, checks;
  int rx_n = 0;
  int tx_n = 0;
  logic [9:0] idxs [9] = '{`T2CRB_IDX_CTRL, `T2CRB_IDX_MODE,
    `T2CRB_IDX_CAPL, `T2CRB_IDX_CAPH, `T2CRB_IDX_CNTL, `T2CRB_IDX_CNTH,
    `T2CRB_IDX_CLKC, `T2CRB_IDX_ISTAT, `T2CRB_IDX_IMASK};
  logic [7:0] mdl [int];
  always #10 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    rx_n <= rx_n + (rx_tick === 1'b1);
    tx_n <= tx_n + (tx_tick === 1'b1);
  end
  // ==========================================================
  // Instances; small dividers keep the run short
  t2crb_top #(.DIV_SLOW(2), .DIV_FAST(1)) t2crb_top_i (
    .CLK_SYS(clk_sys), .RESET(rst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .EXT_TRIGGER_PIN(pin),
    .SERIAL_MODE13(ser13), .TIMER1_OVF(tmr1_ovf),
    .RX_BAUD_TICK(rx_tick), .TX_BAUD_TICK(tx_tick), .IRQ(irq));
  t2crb_partner t2crb_partner_i (.clk(clk_sys), .rst(rst),
    .fall_req(fall_req), .hold_low(hold_low), .ovf_en(ovf_en),
    .pin(pin), .tmr1_ovf(tmr1_ovf), .ovf_total(ovf_total));
  // ==========================================================
  // Tasks
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      err_count++;
    end
  endtask : chk
  task automatic apb(input logic w, input logic [9:0] idx,
      input logic [31:0] d, output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    // Ready, read data and error are all taken at the sampling edge
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      err_count++;
      wrap_up();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    logic [31:0] v;
    logic e;
    apb(1'b1, idx, {24'h0, d}, v, e);
  endtask : wr
  task automatic rd_chk(input logic [9:0] idx, input logic [7:0] exp);
    logic [31:0] v;
    logic e;
    apb(1'b0, idx, 32'h0, v, e);
    chk(v, {24'h0, exp});
  endtask : rd_chk
  task automatic wait_bit(input logic [9:0] idx, input int b);
    logic [31:0] v;
    logic e;
    int n;
    n = 0;
    v = 32'h0;
    while (v[b] !== 1'b1 && n < 2000) begin
      apb(1'b0, idx, 32'h0, v, e);
      n++;
    end
    chk({31'h0, v[b]}, 32'h1);
    if (v[b] !== 1'b1) wrap_up();
  endtask : wait_bit
  task automatic fall();
    @(posedge clk_sys);
    fall_req <= 1'b1;
    @(posedge clk_sys);
    fall_req <= 1'b0;
    repeat (10) @(posedge clk_sys);
  endtask : fall
  task automatic set_cnt(input logic [15:0] c, input logic [15:0] r);
    wr(idxs[4], c[7:0]);
    wr(idxs[5], c[15:8]);
    wr(idxs[2], r[7:0]);
    wr(idxs[3], r[15:8]);
  endtask : set_cnt
  // ==========================================================
  // Main sequence
  initial begin
    logic [31:0] v;
    logic e;
    logic [15:0] r;
    int n, rx0, tx0, ov0;
    err_count = 0;
    checks = 0;
    void'($urandom(32'hCD6119D7));
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    foreach (idxs[i]) rd_chk(idxs[i], 8'h00);
    for (int i = 2; i < 6; i++) mdl[i] = 8'($urandom_range(255));
    for (int i = 2; i < 6; i++) wr(idxs[i], mdl[i]);
    for (int i = 2; i < 6; i++) rd_chk(idxs[i], mdl[i]);
    wr(idxs[1], 8'hFF);
    rd_chk(idxs[1], 8'h09);
    apb(1'b0, 10'h100, 32'h0, v, e);
    chk({31'h0, e}, 32'h1);
    chk(v, 32'h0);
    $display("test registers done");
    // Capture with auto clear while stopped
    wr(idxs[1], 8'h08);
    set_cnt(16'hABCD, 16'h0000);
    wr(idxs[8], 8'h03);
    wr(idxs[0], 8'h09);
    fall();
    rd_chk(idxs[2], 8'hCD);
    rd_chk(idxs[3], 8'hAB);
    rd_chk(idxs[4], 8'h00);
    rd_chk(idxs[5], 8'h00);
    rd_chk(idxs[0], 8'h49);
    rd_chk(idxs[7], 8'h02);
    chk({31'h0, irq}, 32'h1);
    wr(idxs[7], 8'h03);
    wr(idxs[8], 8'h00);
    repeat (2) @(posedge clk_sys);
    chk({31'h0, irq}, 32'h0);
    $display("test capture done");
    // Trigger reload, then trigger ignored when disabled
    wr(idxs[1], 8'h00);
    r = 16'($urandom_range(16'hFFFF));
    set_cnt(16'h5555, r);
    wr(idxs[0], 8'h08);
    fall();
    rd_chk(idxs[4], r[7:0]);
    rd_chk(idxs[5], r[15:8]);
    wr(idxs[0], 8'h00);
    set_cnt(16'h5555, r);
    fall();
    rd_chk(idxs[4], 8'h55);
    rd_chk(idxs[0], 8'h00);
    wr(idxs[7], 8'h03);
    $display("test reload done");
    // Counting trigger falls
    set_cnt(16'h0010, r);
    wr(idxs[0], 8'h06);
    n = $urandom_range(5, 1);
    repeat (n) fall();
    wr(idxs[0], 8'h00);
    rd_chk(idxs[4], 8'(16 + n));
    // Slow rate: 104 clocks of run give one step every second clock
    set_cnt(16'h0000, r);
    wr(idxs[0], 8'h04);
    repeat (100) @(posedge clk_sys);
    wr(idxs[0], 8'h00);
    apb(1'b0, idxs[4], 32'h0, v, e);
    chk({31'h0, v >= 32'h32 && v <= 32'h36}, 32'h1);
    $display("test counter done");
    // Upward overflow with reload and interrupt
    wr(idxs[6], 8'h20);
    set_cnt(16'hFFF0, 16'h1200);
    wr(idxs[8], 8'h01);
    wr(idxs[0], 8'h04);
    wait_bit(idxs[0], 7);
    wr(idxs[0], 8'h00);
    rd_chk(idxs[5], 8'h12);
    rd_chk(idxs[7], 8'h01);
    chk({31'h0, irq}, 32'h1);
    wr(idxs[7], 8'h01);
    rd_chk(idxs[7], 8'h00);
    $display("test overflow done");
    // Down counting to the reload value
    wr(idxs[1], 8'h01);
    hold_low <= 1'b1;
    set_cnt(16'h0103, 16'h0100);
    wr(idxs[0], 8'h04);
    wait_bit(idxs[0], 7);
    rd_chk(idxs[0], 8'hC4);
    wr(idxs[0], 8'h00);
    rd_chk(idxs[5], 8'hFF);
    hold_low <= 1'b0;
    wr(idxs[1], 8'h00);
    wr(idxs[7], 8'h03);
    $display("test down done");
    // Baud generation: capture and counter selects are overridden
    ser13 <= 1'b1;
    set_cnt(16'hFFF0, 16'hFFF0);
    wr(idxs[0], 8'h27);
    rx0 = rx_n;
    tx0 = tx_n;
    ov0 = ovf_total;
    ovf_en <= 1'b1;
    repeat (300) @(posedge clk_sys);
    ovf_en <= 1'b0;
    repeat (12) @(posedge clk_sys);
    rd_chk(idxs[0], 8'h27);
    chk({31'h0, (rx_n - rx0) >= 3}, 32'h1);
    chk(32'(tx_n - tx0), 32'(ovf_total - ov0));
    // Transmit from this timer, receive from the idle other timer
    wr(idxs[0], 8'h14);
    repeat (2) @(posedge clk_sys);
    rx0 = rx_n;
    tx0 = tx_n;
    repeat (100) @(posedge clk_sys);
    wr(idxs[0], 8'h00);
    repeat (4) @(posedge clk_sys);
    chk({31'h0, (tx_n - tx0) >= 3}, 32'h1);
    chk(32'(rx_n - rx0), 32'h0);
    $display("test baud done");
    wrap_up();
  end
endmodule : tb_top

// ---- src/t2crb_defs.svh ----
// Register indexes, bit positions and reset values of the timer block
`ifndef T2CRB_DEFS_SVH
`define T2CRB_DEFS_SVH
// ==========================================================
// Register indexes (byte address is four times the index)
`define T2CRB_IDX_CTRL 10'h0C8
`define T2CRB_IDX_MODE 10'h0C9
`define T2CRB_IDX_CAPL 10'h0CA
`define T2CRB_IDX_CAPH 10'h0CB
`define T2CRB_IDX_CNTL 10'h0CC
`define T2CRB_IDX_CNTH 10'h0CD
`define T2CRB_IDX_CLKC 10'h0E0
`define T2CRB_IDX_ISTAT 10'h0E1
`define T2CRB_IDX_IMASK 10'h0E2
// ==========================================================
// Control register bits
`define T2CRB_B_OVF 7
`define T2CRB_B_EXF 6
`define T2CRB_B_RCLK 5
`define T2CRB_B_TRANSMIT_CLOCK_SELECT 4
`define T2CRB_B_EXEN 3
`define T2CRB_B_RUN 2
`define T2CRB_B_CT 1
`define T2CRB_B_CP 0
// Mode register bits
`define T2CRB_B_CRST 3
`define T2CRB_B_DOWN_COUNT_ENABLE 0
// Clock control register bit
`define T2CRB_B_SPEED 5
// Interrupt status bits
`define T2CRB_I_OVF 0
`define T2CRB_I_EXF 1
// ==========================================================
// Reset values and constants
`define T2CRB_RST_BYTE 8'h00
`define T2CRB_RST_WORD 16'h0000
`define T2CRB_ALL_ONES 16'hFFFF
`define T2CRB_RST_INT 2'h0
`define T2CRB_DIV_SLOW 12
`define T2CRB_DIV_FAST 4
`endif

// ---- src/t2crb_pkg.sv ----
// Types of the timer block: bus phase and the full state record
package t2crb_pkg;
  // ==========================================================
  // Bus phase
  typedef enum logic [0:0] {
    T2CRB_PH_IDLE = 1'b0,
    T2CRB_PH_DONE = 1'b1
  } t2crb_phase_t;
  // ==========================================================
  // Whole state of the block
  typedef struct packed {
    logic ex_meta;
    logic ex_sync;
    logic ex_prev;
    logic [7:0] pre_cnt;
    logic [15:0] cnt;
    logic [15:0] rcap;
    logic [7:0] ctrl;
    logic crst;
    logic down_count_enable;
    logic speed;
    logic [1:0] istat;
    logic [1:0] imask;
    t2crb_phase_t phase;
    logic [31:0] prdata;
    logic pslverr;
    logic irq;
    logic rx_tick;
    logic tx_tick;
  } t2crb_state_t;
endpackage : t2crb_pkg

// ---- src/t2crb_top.sv ----
// Timer two with capture, auto-reload and baud generation, APB slave
// ==========================================================
// Overview of operation
// [RQ1] Overflow flag sets on 16-bit overflow and on count equal reload when down.
// [RQ2] Hardware sets overflow flag only with both clock selects zero.
// [RQ3] External flag sets on trigger fall or under/overflow per mode bits.
// [RQ4] Edge or software set of external flag raises the interrupt.
// [RQ5] Receive select picks this timer's or the other timer's overflow.
// [RQ6] Transmit select picks this timer's or the other timer's overflow.
// [RQ7] External enable lets trigger falls capture or reload, not in baud mode; code also ignores them in down mode.
// [RQ8] Run control starts counting; when stopped the count holds except on trigger capture or reload.
// [RQ9] Counter/timer select picks prescaled clock or trigger falling edges.
// [RQ10] Either clock select forces baud mode over the counter select.
// [RQ11] Capture/reload select picks auto-reload at 0 and capture at 1.
// [RQ12] In baud mode the count reloads after every overflow.
// [RQ13] Capture reset clears the count right after a capture.
// [RQ14] Down-count enable controls direction in auto-reload mode.
// [RQ15] Reload pair latches the count on capture and supplies reloads.
// [RQ16] Counting up wraps from all ones and reloads in the same cycle.
// [RQ17] Down mode: pin level sets direction; underflow loads all ones.
`timescale 1ns/10ps
`include "t2crb_defs.svh"
module t2crb_top #(
  parameter int DIV_SLOW = `T2CRB_DIV_SLOW,
  parameter int DIV_FAST = `T2CRB_DIV_FAST
) (
  input wire logic CLK_SYS,
  input wire logic RESET,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic EXT_TRIGGER_PIN,
  input wire logic SERIAL_MODE13,
  input wire logic TIMER1_OVF,
  output logic RX_BAUD_TICK,
  output logic TX_BAUD_TICK,
  output logic IRQ
);
  // ==========================================================
  // Parameter checks
  // Prescaler is eight bits wide, so 256 is the largest divide
  if (DIV_SLOW < 1 || DIV_SLOW > 256 ||
      DIV_FAST < 1 || DIV_FAST > 256) begin : g_div_chk
    $error("t2crb_top: prescaler divide out of range");
  end

  localparam logic [7:0] DIV_SLOW_M1 = 8'(DIV_SLOW - 1);
  localparam logic [7:0] DIV_FAST_M1 = 8'(DIV_FAST - 1);

  t2crb_pkg::t2crb_state_t st_reg;
  t2crb_pkg::t2crb_state_t st_next;

  // ==========================================================
  // Decoded control
  logic baud;
  logic ex_fall;
  logic pre_wrap;
  logic cnt_step;
  logic edge_act;
  logic t2_wrap;
  logic dn_mode;
  logic acc_wr;
  logic mapped;
  logic [9:0] idx;
  logic [7:0] wbyte;
  logic wr_ctrl;
  logic wr_cntl;
  logic wr_cnth;
  logic wr_capl;
  logic wr_caph;
  logic [31:0] rd_val;
  logic hw_ovf;
  logic hw_exf_set;
  logic hw_exf_tog;
  logic cap_evt;
  logic [15:0] cnt_hw;
  logic [15:0] rcap_hw;

  assign idx = PADDR[11:2];
  assign wbyte = PWDATA[7:0];
  // Either clock select forces baud generation [RQ10]
  assign baud = st_reg.ctrl[`T2CRB_B_RCLK] | st_reg.ctrl[`T2CRB_B_TRANSMIT_CLOCK_SELECT];
  assign ex_fall = st_reg.ex_prev & ~st_reg.ex_sync;
  assign pre_wrap = st_reg.pre_cnt == (st_reg.speed ? DIV_FAST_M1 :
                                       DIV_SLOW_M1);
  // Prescaled clock or trigger edges; baud mode always internal [RQ9]
  assign cnt_step = st_reg.ctrl[`T2CRB_B_RUN] &
                    ((st_reg.ctrl[`T2CRB_B_CT] & ~baud) ? ex_fall :
                     pre_wrap); // [RQ8]
  // Trigger capture or reload only outside baud and down mode [RQ7]
  assign edge_act = ex_fall & st_reg.ctrl[`T2CRB_B_EXEN] & ~baud &
                    ~dn_mode;
  // Direction control only in auto-reload [RQ14]
  assign dn_mode = st_reg.down_count_enable & ~st_reg.ctrl[`T2CRB_B_CP] & ~baud;
  assign t2_wrap = cnt_step & (st_reg.cnt == `T2CRB_ALL_ONES) &
                   (~dn_mode | st_reg.ex_sync);

  always_comb begin
    mapped = 1'b1;
    rd_val = 32'h00000000;
    case (idx)
      `T2CRB_IDX_CTRL: rd_val = {24'h000000, st_reg.ctrl};
      `T2CRB_IDX_MODE: rd_val = {28'h0000000, st_reg.crst, 2'h0,
                                 st_reg.down_count_enable};
      `T2CRB_IDX_CAPL: rd_val = {24'h000000, st_reg.rcap[7:0]};
      `T2CRB_IDX_CAPH: rd_val = {24'h000000, st_reg.rcap[15:8]};
      `T2CRB_IDX_CNTL: rd_val = {24'h000000, st_reg.cnt[7:0]};
      `T2CRB_IDX_CNTH: rd_val = {24'h000000, st_reg.cnt[15:8]};
      `T2CRB_IDX_CLKC: rd_val = {26'h0000000, st_reg.speed, 5'h00};
      `T2CRB_IDX_ISTAT: rd_val = {30'h00000000, st_reg.istat};
      `T2CRB_IDX_IMASK: rd_val = {30'h00000000, st_reg.imask};
      default: mapped = 1'b0;
    endcase
  end

  // Write commits only at the edge where the answer is seen
  assign acc_wr = PSEL & PENABLE & PWRITE & mapped &
                  (st_reg.phase == t2crb_pkg::T2CRB_PH_DONE);
  assign wr_ctrl = acc_wr & (idx == `T2CRB_IDX_CTRL);
  assign wr_cntl = acc_wr & (idx == `T2CRB_IDX_CNTL);
  assign wr_cnth = acc_wr & (idx == `T2CRB_IDX_CNTH);
  assign wr_capl = acc_wr & (idx == `T2CRB_IDX_CAPL);
  assign wr_caph = acc_wr & (idx == `T2CRB_IDX_CAPH);

  // ==========================================================
  // Counting engine
  always_comb begin
    cnt_hw = st_reg.cnt;
    rcap_hw = st_reg.rcap;
    hw_ovf = 1'b0;
    hw_exf_set = 1'b0;
    hw_exf_tog = 1'b0;
    cap_evt = 1'b0;
    if (baud) begin
      if (cnt_step) begin
        // Baud mode reloads after every overflow [RQ12]
        cnt_hw = t2_wrap ? st_reg.rcap : st_reg.cnt + 16'h0001;
      end
    end else if (dn_mode) begin
      if (cnt_step && st_reg.ex_sync) begin
        cnt_hw = t2_wrap ? st_reg.rcap : st_reg.cnt + 16'h0001; // [RQ17]
        hw_ovf = t2_wrap;
        hw_exf_tog = t2_wrap;
      end else if (cnt_step) begin
        if (st_reg.cnt == st_reg.rcap) begin
          cnt_hw = `T2CRB_ALL_ONES; // [RQ17]
          hw_ovf = 1'b1; // [RQ1]
          hw_exf_tog = 1'b1; // [RQ3]
        end else begin
          cnt_hw = st_reg.cnt - 16'h0001;
        end
      end
    end else if (st_reg.ctrl[`T2CRB_B_CP]) begin
      // Capture mode: count wraps to zero [RQ11]
      if (cnt_step) begin
        cnt_hw = st_reg.cnt + 16'h0001;
        hw_ovf = t2_wrap; // [RQ1]
      end
      if (edge_act) begin
        cap_evt = 1'b1;
        rcap_hw = st_reg.cnt; // [RQ15]
        hw_exf_set = 1'b1; // [RQ3]
        if (st_reg.crst) begin
          cnt_hw = `T2CRB_RST_WORD; // [RQ13]
        end
      end
    end else begin
      if (cnt_step) begin
        // Wrap reloads from the pair at once [RQ16] [RQ15]
        cnt_hw = t2_wrap ? st_reg.rcap : st_reg.cnt + 16'h0001;
        hw_ovf = t2_wrap;
      end
      if (edge_act) begin
        cnt_hw = st_reg.rcap; // [RQ11]
        hw_exf_set = 1'b1; // [RQ3]
      end
    end
  end

  // ==========================================================
  // Next state
  always_comb begin
    st_next = st_reg;
    // Pin passes two flops before the edge detector reads it
    st_next.ex_meta = EXT_TRIGGER_PIN;
    st_next.ex_sync = st_reg.ex_meta;
    st_next.ex_prev = st_reg.ex_sync;
    // Prescaler free-runs so the rate stays even across stops
    st_next.pre_cnt = pre_wrap ? 8'h00 : st_reg.pre_cnt + 8'h01;
    st_next.cnt = cnt_hw;
    st_next.rcap = rcap_hw;
    // Software byte writes win over counting in the same cycle
    if (wr_cntl) begin
      st_next.cnt[7:0] = wbyte;
    end
    if (wr_cnth) begin
      st_next.cnt[15:8] = wbyte;
    end
    if (wr_capl) begin
      st_next.rcap[7:0] = wbyte;
    end
    if (wr_caph) begin
      st_next.rcap[15:8] = wbyte;
    end
    if (wr_ctrl) begin
      st_next.ctrl = wbyte;
    end
    // Hardware set beats software clear; flag held off in baud [RQ2]
    if (hw_ovf && !baud) begin
      st_next.ctrl[`T2CRB_B_OVF] = 1'b1; // [RQ1]
    end
    if (hw_exf_set) begin
      st_next.ctrl[`T2CRB_B_EXF] = 1'b1;
    end else if (hw_exf_tog) begin
      st_next.ctrl[`T2CRB_B_EXF] = ~st_reg.ctrl[`T2CRB_B_EXF];
    end
    if (acc_wr && idx == `T2CRB_IDX_MODE) begin
      st_next.crst = wbyte[`T2CRB_B_CRST];
      st_next.down_count_enable = wbyte[`T2CRB_B_DOWN_COUNT_ENABLE];
    end
    if (acc_wr && idx == `T2CRB_IDX_CLKC) begin
      st_next.speed = wbyte[`T2CRB_B_SPEED];
    end
    if (acc_wr && idx == `T2CRB_IDX_IMASK) begin
      st_next.imask = wbyte[1:0];
    end
    // Sticky status, write one to clear; a new event wins
    if (acc_wr && idx == `T2CRB_IDX_ISTAT) begin
      st_next.istat = st_reg.istat & ~wbyte[1:0];
    end
    if (hw_ovf && !baud) begin
      st_next.istat[`T2CRB_I_OVF] = 1'b1;
    end
    if (wr_ctrl && wbyte[`T2CRB_B_OVF] && !st_reg.ctrl[`T2CRB_B_OVF]) begin
      st_next.istat[`T2CRB_I_OVF] = 1'b1;
    end
    // Toggles in down mode do not interrupt [RQ4]
    if (hw_exf_set) begin
      st_next.istat[`T2CRB_I_EXF] = 1'b1;
    end
    if (wr_ctrl && wbyte[`T2CRB_B_EXF] && !st_reg.ctrl[`T2CRB_B_EXF]) begin
      st_next.istat[`T2CRB_I_EXF] = 1'b1;
    end
    st_next.irq = |(st_next.istat & st_next.imask); // [RQ4]
    // Baud ticks only in serial modes 1 and 3 [RQ5] [RQ6]
    st_next.rx_tick = SERIAL_MODE13 &
                      (st_reg.ctrl[`T2CRB_B_RCLK] ? t2_wrap : TIMER1_OVF);
    st_next.tx_tick = SERIAL_MODE13 &
                      (st_reg.ctrl[`T2CRB_B_TRANSMIT_CLOCK_SELECT] ? t2_wrap : TIMER1_OVF);
    // One wait state keeps read data and ready straight from flops
    case (st_reg.phase)
      t2crb_pkg::T2CRB_PH_IDLE: begin
        if (PSEL && PENABLE) begin
          st_next.phase = t2crb_pkg::T2CRB_PH_DONE;
          st_next.prdata = PWRITE ? 32'h00000000 : rd_val;
          st_next.pslverr = ~mapped;
        end
      end
      t2crb_pkg::T2CRB_PH_DONE: begin
        st_next.phase = t2crb_pkg::T2CRB_PH_IDLE;
        st_next.pslverr = 1'b0;
      end
      default: st_next.phase = t2crb_pkg::T2CRB_PH_IDLE;
    endcase
  end

  // ==========================================================
  // State register
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign PRDATA = st_reg.prdata;
  assign PREADY = st_reg.phase == t2crb_pkg::T2CRB_PH_DONE;
  assign PSLVERR = st_reg.pslverr;
  assign IRQ = st_reg.irq;
  assign RX_BAUD_TICK = st_reg.rx_tick;
  assign TX_BAUD_TICK = st_reg.tx_tick;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RESET);

  logic any_cnt_wr;
  assign any_cnt_wr = wr_cntl | wr_cnth;

  ovf_flag_set_a: assert property ( // [RQ1]
    (cnt_step && !baud && !dn_mode && st_reg.cnt == `T2CRB_ALL_ONES)
    |=> st_reg.ctrl[`T2CRB_B_OVF])
    else $error("overflow flag not set on wrap");
  baud_no_flag_a: assert property ( // [RQ2]
    (baud && !wr_ctrl && !st_reg.ctrl[`T2CRB_B_OVF])
    |=> !st_reg.ctrl[`T2CRB_B_OVF])
    else $error("overflow flag set in baud mode");
  edge_ext_flag_a: assert property ( // [RQ3]
    (ex_fall && st_reg.ctrl[`T2CRB_B_EXEN] && !baud && !dn_mode)
    |=> st_reg.ctrl[`T2CRB_B_EXF] && st_reg.istat[`T2CRB_I_EXF])
    else $error("external flag missed a trigger edge");
  irq_level_a: assert property ( // [RQ4]
    IRQ == |(st_reg.istat & st_reg.imask))
    else $error("interrupt output disagrees with status and mask");
  rx_source_a: assert property ( // [RQ5]
    (SERIAL_MODE13 && st_reg.ctrl[`T2CRB_B_RCLK] && t2_wrap)
    |=> RX_BAUD_TICK)
    else $error("receive tick missing on timer wrap");
  tx_source_a: assert property ( // [RQ6]
    (SERIAL_MODE13 && !st_reg.ctrl[`T2CRB_B_TRANSMIT_CLOCK_SELECT] && TIMER1_OVF)
    |=> TX_BAUD_TICK)
    else $error("transmit tick missing on other timer overflow");
  exen_off_a: assert property ( // [RQ7]
    (!st_reg.ctrl[`T2CRB_B_EXEN] && !cnt_step && !any_cnt_wr)
    |=> $stable(st_reg.cnt))
    else $error("count moved with trigger disabled");
  stop_hold_a: assert property ( // [RQ8]
    (!st_reg.ctrl[`T2CRB_B_RUN] && !edge_act && !any_cnt_wr)
    |=> $stable(st_reg.cnt))
    else $error("count moved while stopped");
  baud_reload_a: assert property ( // [RQ12]
    (baud && t2_wrap && !any_cnt_wr) |=> st_reg.cnt == $past(st_reg.rcap))
    else $error("no reload after baud overflow");
  cap_clear_a: assert property ( // [RQ13]
    (cap_evt && st_reg.crst && !any_cnt_wr && !wr_capl && !wr_caph)
    |=> st_reg.cnt == `T2CRB_RST_WORD &&
        st_reg.rcap == $past(st_reg.cnt))
    else $error("capture or capture reset wrong");
  down_under_a: assert property ( // [RQ17]
    (dn_mode && cnt_step && !st_reg.ex_sync &&
     st_reg.cnt == st_reg.rcap && !any_cnt_wr)
    |=> st_reg.cnt == `T2CRB_ALL_ONES && st_reg.ctrl[`T2CRB_B_OVF])
    else $error("down-count underflow wrong");
  apb_ready_a: assert property (
    (PSEL && PENABLE && !PREADY) |=> PREADY ##1 !PREADY)
    else $error("bus answer not one wait state");
  bus_error_a: assert property (
    (PSEL && PENABLE && !PREADY && !mapped)
    |=> PSLVERR && PRDATA == 32'h00000000)
    else $error("unmapped access not refused");
  // Counter mode, reload paths, direction control and baud tick sources; count checks exclude writes
  count_edges_a: assert property ( // [RQ9]
    (st_reg.ctrl[`T2CRB_B_CT] && !baud && !ex_fall && !any_cnt_wr)
    |=> $stable(st_reg.cnt))
    else $error("counter mode moved without a trigger edge");
  up_reload_a: assert property ( // [RQ16]
    (t2_wrap && !dn_mode && !baud && !st_reg.ctrl[`T2CRB_B_CP] &&
     !edge_act && !any_cnt_wr)
    |=> st_reg.cnt == $past(st_reg.rcap))
    else $error("no reload after upward wrap");
  trig_reload_a: assert property ( // [RQ11]
    (edge_act && !st_reg.ctrl[`T2CRB_B_CP] && !any_cnt_wr)
    |=> st_reg.cnt == $past(st_reg.rcap))
    else $error("trigger edge did not reload the count");
  down_step_a: assert property ( // [RQ14]
    (dn_mode && cnt_step && !st_reg.ex_sync &&
     st_reg.cnt != st_reg.rcap && !any_cnt_wr)
    |=> st_reg.cnt == $past(st_reg.cnt) - 16'h0001)
    else $error("down count did not step by one");
  rx_other_a: assert property ( // [RQ5]
    (SERIAL_MODE13 && !st_reg.ctrl[`T2CRB_B_RCLK] && TIMER1_OVF)
    |=> RX_BAUD_TICK)
    else $error("receive tick missing on other timer overflow");
  tx_own_a: assert property ( // [RQ6]
    (SERIAL_MODE13 && st_reg.ctrl[`T2CRB_B_TRANSMIT_CLOCK_SELECT] && t2_wrap)
    |=> TX_BAUD_TICK)
    else $error("transmit tick missing on timer wrap");

  baud_tick_c: cover property (baud && t2_wrap ##1 RX_BAUD_TICK);
  capture_c: cover property (cap_evt && st_reg.crst);
  down_under_c: cover property (dn_mode && hw_exf_tog);
  irq_c: cover property (!IRQ ##1 IRQ);
  reload_edge_c: cover property (edge_act && !st_reg.ctrl[`T2CRB_B_CP]);
endmodule : t2crb_top
